/* File: src/fspg_guard.sv */
// Purpose: Self-programming access guard with sectioning, locks and reset vector.
// Assumes: Core issues store/load pulses in aclk domain; fuse pins are static straps.
// Notes: Flash timing comes from flash_done input.
// Summary of operation
// - Programming the concurrent region leaves halting region fetchable and CPU running.
// - Concurrent region is unreadable during a concurrent-region erase or write.
// - The boot area lies wholly inside the halting region.
// - Busy flag reads one while the concurrent region is blocked.
// - Erase or write of halting region halts the CPU throughout.
// - Application and boot lock fields are independent and separately settable.
// - Lock bits are programmed by software or programmer, cleared only by chip erase; aresetn also restores them to ones.
// - General lock modes never restrict program-memory loads or stores.
// - App lock 11 unrestricted; 10 blocks stores to application area.
// - App lock 00 blocks stores and boot loads; 01 blocks only loads.
// - App lock 00/01 with boot vectors disables interrupts in application area.
// - Boot lock 11 unrestricted; 10 blocks stores to boot area.
// - Boot lock 00 blocks stores and application loads; 01 blocks loads.
// - Boot lock 00/01 with application vectors disables interrupts in boot area.
// - Boot-reset fuse one starts at zero; zero starts at boot reset address; reset_vector reads zero for either fuse until the second edge after reset.
// - CPU cannot alter any fuse.
// - Control register is 8 bits, reset zero, bit 6 busy, bit 5 reads zero.
// - Store enable permits a store only for four cycles, then clears.
// - Only the five documented low-bit patterns take effect.
// - Busy sets on concurrent program start, clears on re-enable or buffer fill.
// - Ready interrupt requested while enabled, global flag set, and store enable clear.
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module fspg_guard #(
  parameter int ADDR_W = 12,
  parameter logic [11:0] HALT_BASE = 12'hc00,
  parameter logic [11:0] BOOT_BASE = 12'he00
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core program-memory operations.
  input wire logic store_req,
  input wire logic [ADDR_W-1:0] store_addr,
  input wire logic [3:0] lock_data,
  input wire logic load_req,
  input wire logic [ADDR_W-1:0] load_addr,
  input wire logic [ADDR_W-1:0] fetch_pc,
  input wire logic global_irq_flag,
  input wire logic vectors_in_boot,
  // Flash macro.
  output logic flash_erase,
  output logic flash_write,
  output logic flash_fill,
  output logic flash_abort,
  output logic [ADDR_W-1:0] flash_addr,
  input wire logic flash_done,
  // Programmer port and straps.
  input wire logic chip_erase,
  input wire logic prog_lock_we,
  input wire logic [3:0] prog_lock_data,
  input wire logic boot_reset_select_fuse,
  // Core controls.
  output logic cpu_halt,
  output logic concurrent_region_blocked,
  output logic store_granted,
  output logic load_granted,
  output logic irq_disable,
  output logic program_ready_irq,
  output logic [ADDR_W-1:0] reset_vector
);
  fspg_pkg::fspg_state_type state_q;
  logic [7:0] ctrl_q;
  logic [3:0] lock_q;
  logic [2:0] window_q;
  logic halt_target_q;
  logic busy_q;
  logic [1:0] fuse_sync_q;
  logic [1:0] ce_sync_q;
  logic wr_go, rd_go, ctrl_wr, store_fire, store_halt_area, store_boot, load_boot, pc_boot;
  logic app_store_ok, app_load_ok, app_irq_guard, boot_store_ok, boot_load_ok, boot_irq_guard;
  logic [4:0] cmd;

  // Two-stage synchronisers for the fuse and chip-erase pins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fuse_sync_q <= 2'h3;
      ce_sync_q <= 2'h0;
    end else begin
      fuse_sync_q <= {fuse_sync_q[0], boot_reset_select_fuse};
      ce_sync_q <= {ce_sync_q[0], chip_erase};
    end
  end

  // The fuse is only observed, never written, by this logic.
  assign reset_vector = fuse_sync_q[1] ? '0 : BOOT_BASE;

  // Per-area lock decoders.
  fspg_lock_check u_app_lock (
    .lock_field(lock_q[1:0]),
    .store_ok(app_store_ok),
    .cross_load_ok(app_load_ok),
    .irq_guard(app_irq_guard)
  );
  fspg_lock_check u_boot_lock (
    .lock_field(lock_q[3:2]),
    .store_ok(boot_store_ok),
    .cross_load_ok(boot_load_ok),
    .irq_guard(boot_irq_guard)
  );

  // Area decode; boot area sits above the halting base so it is never concurrent.
  always_comb begin
    store_halt_area = store_addr >= HALT_BASE;
    store_boot = store_addr >= BOOT_BASE;
    load_boot = load_addr >= BOOT_BASE;
    pc_boot = fetch_pc >= BOOT_BASE;
  end

  // Bus handshakes: write taken when address and data both present, one at a time.
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready = s_axi_awready;
  assign s_axi_arready = s_axi_arvalid && !s_axi_rvalid;
  assign wr_go = s_axi_awready;
  assign rd_go = s_axi_arready;
  assign ctrl_wr = wr_go && s_axi_awaddr == fspg_pkg::CTRL_OFFSET && s_axi_wstrb[0];
  assign cmd = s_axi_wdata[4:0];

  // A store fires only inside the armed window; only stores from boot code count.
  assign store_fire = store_req && state_q == fspg_pkg::ST_ARMED && pc_boot;

  // Store permission by lock fields, bypassed for lock-set and re-enable stores; general lock modes are not consulted.
  always_comb begin
    if (ctrl_q[fspg_pkg::LOCKSET_BIT] || ctrl_q[fspg_pkg::REENABLE_BIT]) begin
      store_granted = store_fire;
    end else begin
      store_granted = store_fire && (store_boot ? boot_store_ok : app_store_ok);
    end
  end

  // Load permission: cross-area loads checked against the target area field.
  always_comb begin
    if (concurrent_region_blocked && load_addr < HALT_BASE) begin
      load_granted = 1'b0;
    end else if (pc_boot && !load_boot) begin
      load_granted = load_req && app_load_ok;
    end else if (!pc_boot && load_boot) begin
      load_granted = load_req && boot_load_ok;
    end else begin
      load_granted = load_req;
    end
  end

  // Interrupt masking while executing in a protected area.
  assign irq_disable = (vectors_in_boot && !pc_boot && app_irq_guard) ||
                       (!vectors_in_boot && pc_boot && boot_irq_guard);

  // Ready interrupt while enabled, global flag set and store enable clear.
  assign program_ready_irq = ctrl_q[fspg_pkg::IRQ_EN_BIT] && global_irq_flag &&
                             !ctrl_q[fspg_pkg::STORE_EN_BIT];

  // Halting region programming stalls the core for the whole operation.
  assign cpu_halt = state_q == fspg_pkg::ST_BUSY && halt_target_q;

  // Sequencer and control register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= fspg_pkg::ST_IDLE;
      ctrl_q <= fspg_pkg::CTRL_RESET;
      window_q <= 3'h0;
      halt_target_q <= 1'b0;
    end else begin
      case (state_q)
        fspg_pkg::ST_IDLE: begin
          if (ctrl_wr) begin
            ctrl_q[fspg_pkg::IRQ_EN_BIT] <= s_axi_wdata[fspg_pkg::IRQ_EN_BIT];
            if (cmd == fspg_pkg::CMD_REENABLE || cmd == fspg_pkg::CMD_LOCKSET ||
                cmd == fspg_pkg::CMD_PGWRITE || cmd == fspg_pkg::CMD_PGERASE ||
                cmd == fspg_pkg::CMD_FILL) begin
              ctrl_q[4:0] <= cmd;
              window_q <= fspg_pkg::STORE_WINDOW;
              state_q <= fspg_pkg::ST_ARMED;
            end
          end
        end
        fspg_pkg::ST_ARMED: begin
          if (store_granted && (ctrl_q[fspg_pkg::PGWRITE_BIT] || ctrl_q[fspg_pkg::PGERASE_BIT])) begin
            halt_target_q <= store_halt_area;
            state_q <= fspg_pkg::ST_BUSY;
          end else if (store_fire || window_q == 3'h1) begin
            ctrl_q[4:0] <= 5'h00;
            state_q <= fspg_pkg::ST_IDLE;
          end else begin
            window_q <= window_q - 3'h1;
          end
        end
        fspg_pkg::ST_BUSY: begin
          if (flash_done) begin
            ctrl_q[4:0] <= 5'h00;
            state_q <= fspg_pkg::ST_IDLE;
          end
        end
        default: state_q <= fspg_pkg::ST_IDLE;
      endcase
    end
  end

  // Busy flag: set on concurrent program start, cleared by re-enable or fill.
  // It is its own register so that only this process ever drives it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
    end else if (store_granted && !store_halt_area &&
                 (ctrl_q[fspg_pkg::PGWRITE_BIT] || ctrl_q[fspg_pkg::PGERASE_BIT])) begin
      busy_q <= 1'b1;
    end else if (store_granted &&
                 (ctrl_q[fspg_pkg::REENABLE_BIT] || ctrl_q[4:0] == fspg_pkg::CMD_FILL)) begin
      busy_q <= 1'b0;
    end
  end
  assign concurrent_region_blocked = busy_q;

  // Lock fields: programming only clears bits; chip erase restores ones.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_q <= {fspg_pkg::LOCK_FIELD_RESET, fspg_pkg::LOCK_FIELD_RESET};
    end else if (ce_sync_q[1]) begin
      lock_q <= {fspg_pkg::LOCK_FIELD_RESET, fspg_pkg::LOCK_FIELD_RESET};
    end else if (prog_lock_we) begin
      lock_q <= lock_q & prog_lock_data;
    end else if (store_granted && ctrl_q[fspg_pkg::LOCKSET_BIT]) begin
      lock_q <= lock_q & lock_data;
    end
  end

  // Flash strobes, registered; one-cycle pulses on grant.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_erase <= 1'b0;
      flash_write <= 1'b0;
      flash_fill <= 1'b0;
      flash_abort <= 1'b0;
      flash_addr <= '0;
    end else begin
      flash_erase <= store_granted && ctrl_q[4:0] == fspg_pkg::CMD_PGERASE;
      flash_write <= store_granted && ctrl_q[4:0] == fspg_pkg::CMD_PGWRITE;
      flash_fill <= store_granted && ctrl_q[4:0] == fspg_pkg::CMD_FILL;
      flash_abort <= store_granted && ctrl_q[fspg_pkg::REENABLE_BIT];
      if (store_granted) begin
        flash_addr <= store_addr;
      end
    end
  end

  // Write response: one cycle after acceptance, held until bready.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= fspg_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (s_axi_awaddr == fspg_pkg::CTRL_OFFSET) ? fspg_pkg::RESP_OKAY :
                     fspg_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read data: control, locks, core view, status; bit 5 always zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= fspg_pkg::RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= fspg_pkg::RESP_OKAY;
      case (s_axi_araddr)
        fspg_pkg::CTRL_OFFSET: s_axi_rdata <= {24'h000000, ctrl_q[7], busy_q, 1'b0, ctrl_q[4:0]};
        fspg_pkg::LOCK_OFFSET: s_axi_rdata <= {28'h0000000, lock_q};
        fspg_pkg::CORE_OFFSET: s_axi_rdata <= {31'h0000000, fuse_sync_q[1]};
        fspg_pkg::STAT_OFFSET: s_axi_rdata <= {29'h0000000, cpu_halt, irq_disable,
                                               program_ready_irq};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= fspg_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: src/fspg_pkg.sv */
// Purpose: Shared constants for the flash self-program guard.
// Assumes: AXI4-Lite register access, 32-bit data, 100 MHz core clock.
// Notes: Offsets and field positions are named once here.
package fspg_pkg;
  // Register byte offsets.
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] LOCK_OFFSET = 8'h04;
  localparam logic [7:0] CORE_OFFSET = 8'h08;
  localparam logic [7:0] STAT_OFFSET = 8'h0c;
  // Control register field positions.
  localparam int IRQ_EN_BIT = 7;
  localparam int BUSY_BIT = 6;
  localparam int REENABLE_BIT = 4;
  localparam int LOCKSET_BIT = 3;
  localparam int PGWRITE_BIT = 2;
  localparam int PGERASE_BIT = 1;
  localparam int STORE_EN_BIT = 0;
  // Command patterns of the low five control bits.
  localparam logic [4:0] CMD_REENABLE = 5'h11;
  localparam logic [4:0] CMD_LOCKSET = 5'h09;
  localparam logic [4:0] CMD_PGWRITE = 5'h05;
  localparam logic [4:0] CMD_PGERASE = 5'h03;
  localparam logic [4:0] CMD_FILL = 5'h01;
  // Reset values.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] LOCK_FIELD_RESET = 2'h3;
  // Store-enable window length in cycles.
  localparam logic [2:0] STORE_WINDOW = 3'h4;
  // Response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Sequencer states.
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_BUSY} fspg_state_type;
endpackage

/* File: src/fspg_lock_check.sv */
// Purpose: Decodes one two-bit lock field into store and load permissions.
// Assumes: Field bit value 1 means unprogrammed.
// Notes: Instantiated once per flash area.
`timescale 1ns/10ps
`default_nettype none
module fspg_lock_check (
  // Lock field.
  input wire logic [1:0] lock_field,
  // Permissions.
  output logic store_ok,
  output logic cross_load_ok,
  output logic irq_guard
);
  // Low bit low blocks stores; high bit low blocks cross-area loads.
  always_comb begin
    store_ok = lock_field == 2'h3 || lock_field == 2'h1;
    cross_load_ok = lock_field[1];
    irq_guard = ~lock_field[1];
  end
endmodule
`default_nettype wire

/* File: test/fspg_guard_asserts.sv */
// Purpose: Port-level checks for the self-program guard.
// Assumes: One clock, synchronous active-low reset.
// Notes: Attached to every guard instance by the bind below.
`timescale 1ns/10ps
`default_nettype none
module fspg_guard_asserts #(
  parameter int ADDR_W = 12,
  parameter logic [11:0] HALT_BASE = 12'hc00
) (
  // Clock, reset and write address channel.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awready,
  // Core side.
  input wire logic store_granted,
  input wire logic load_req,
  input wire logic [ADDR_W-1:0] load_addr,
  input wire logic load_granted,
  input wire logic global_irq_flag,
  input wire logic program_ready_irq,
  input wire logic cpu_halt,
  input wire logic concurrent_region_blocked,
  // Flash side.
  input wire logic flash_erase,
  input wire logic flash_write,
  input wire logic flash_fill,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic flash_done
);
  logic [2:0] win_q;
  logic prog;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // An erase or write starts this cycle.
  assign prog = flash_erase || flash_write;
  // Cycles since a control write; it saturates so a stale arm never looks fresh.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win_q <= 3'h7;
    end else if (s_axi_awready && s_axi_awaddr == fspg_pkg::CTRL_OFFSET) begin
      win_q <= 3'h0;
    end else if (win_q != 3'h7) begin
      win_q <= win_q + 3'h1;
    end
  end
  property p_halt_prog;
    prog && flash_addr >= HALT_BASE |=> cpu_halt;
  endproperty
  a_halt_prog: assert property (p_halt_prog) else $error("no halt");
  property p_halt_hold;
    cpu_halt && !flash_done |=> cpu_halt;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt dropped");
  property p_rww_prog;
    prog && flash_addr < HALT_BASE |=> !cpu_halt && concurrent_region_blocked;
  endproperty
  a_rww_prog: assert property (p_rww_prog) else $error("bad rww state");
  property p_rww_load;
    concurrent_region_blocked && load_req && load_addr < HALT_BASE |-> !load_granted;
  endproperty
  a_rww_load: assert property (p_rww_load) else $error("rww load");
  property p_fill_clear;
    flash_fill |=> !concurrent_region_blocked;
  endproperty
  a_fill_clear: assert property (p_fill_clear) else $error("busy kept");
  property p_denied;
    !store_granted |=> !(prog || flash_fill);
  endproperty
  a_denied: assert property (p_denied) else $error("stray pulse");
  property p_irq;
    !global_irq_flag || store_granted |-> !program_ready_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("ready irq");
  property p_window;
    store_granted |-> win_q <= 3'h4;
  endproperty
  a_window: assert property (p_window) else $error("late store");
  cover property (prog && flash_addr >= HALT_BASE);
  cover property (flash_fill);
  cover property (store_granted);
endmodule
bind fspg_guard fspg_guard_asserts #(.ADDR_W(ADDR_W), .HALT_BASE(HALT_BASE)) fspg_guard_asserts_inst (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awready, .store_granted, .load_req, .load_addr,
  .load_granted, .global_irq_flag, .program_ready_irq, .cpu_halt, .concurrent_region_blocked,
  .flash_erase, .flash_write, .flash_fill, .flash_addr, .flash_done);
`default_nettype wire

/* File: test/fspg_flash_model.sv */
// Purpose: Flash macro stand-in that ends erase and write.
// Assumes: Every erase or write takes DELAY cycles.
// Notes: A long delay leaves room for traffic during programming.
`timescale 1ns/10ps
`default_nettype none
module fspg_flash_model #(
  parameter int DELAY = 30
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Operation start and completion.
  input wire logic flash_erase,
  input wire logic flash_write,
  output logic flash_done
);
  int cnt;
  // Count the programming time down; done is a one-cycle pulse.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 0;
      flash_done <= 1'b0;
    end else begin
      flash_done <= (cnt == 1);
      if (flash_erase || flash_write) begin
        cnt <= DELAY;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/test_flash_self_program_guard.sv */
// Purpose: Register and core-operation test of the self-program guard.
// Assumes: Boot area starts at e00, halting region at c00.
// Notes: Programmer lock port is written once, after the chip erase.
`timescale 1ns/10ps
`default_nettype none
module test_flash_self_program_guard;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, store_req;
  logic load_req, global_irq_flag, vectors_in_boot, flash_erase, flash_write, flash_fill;
  logic flash_done, chip_erase, boot_reset_select_fuse, cpu_halt, concurrent_region_blocked;
  logic store_granted, load_granted, irq_disable, program_ready_irq, flash_abort, prog_lock_we;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] lock_data, prog_lock_data;
  logic [11:0] store_addr, load_addr, fetch_pc, flash_addr, reset_vector;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  fspg_guard fspg_guard_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .store_req, .store_addr, .lock_data, .load_req, .load_addr,
    .fetch_pc, .global_irq_flag, .vectors_in_boot, .flash_erase, .flash_write, .flash_fill,
    .flash_abort, .flash_addr, .flash_done, .chip_erase, .prog_lock_we,
    .prog_lock_data, .boot_reset_select_fuse, .cpu_halt, .concurrent_region_blocked,
    .store_granted, .load_granted, .irq_disable, .program_ready_irq, .reset_vector);
  fspg_flash_model fspg_flash_model_inst (.aclk, .aresetn, .flash_erase, .flash_write,
    .flash_done);
  // Free-running 100 MHz clock.
  always #5 aclk = ~aclk;
  task automatic print_verdict;
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // A hang counts as a mismatch and still reaches the verdict.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // Bus write; both channels are offered together and released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata & m);
    chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
  endtask
  // One store or load pulse; the grant is combinational and read mid-cycle.
  task automatic core(input logic st, input logic [11:0] a, input logic [11:0] pc, input logic e);
    store_req <= st;
    load_req <= !st;
    store_addr <= a;
    load_addr <= a;
    fetch_pc <= pc;
    @(negedge aclk);
    chk("grant", {31'h0, e}, {31'h0, st ? store_granted : load_granted});
    @(posedge aclk);
    store_req <= 1'b0;
    load_req <= 1'b0;
  endtask
  task automatic settle;
    do @(posedge aclk); while (!flash_done);
    @(posedge aclk);
  endtask
  // Main sequence.
  initial begin
    {aclk, aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready,
     s_axi_araddr, s_axi_arvalid, s_axi_rready, store_req, store_addr, lock_data, load_req,
     load_addr, fetch_pc, global_irq_flag, vectors_in_boot, chip_erase, prog_lock_we,
     prog_lock_data} = '0;
    boot_reset_select_fuse = 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h00, 32'hff, 32'h0, 2'h0);
    rd(8'h04, 32'hf, 32'hf, 2'h0);
    rd(8'h10, 32'h0, 32'h0, 2'h2);
    wr(8'h00, 32'he0, 2'h0);
    rd(8'h00, 32'hff, 32'h80, 2'h0);
    global_irq_flag <= 1'b1;
    @(negedge aclk);
    chk("irq", 32'h1, {31'h0, program_ready_irq});
    @(posedge aclk);
    global_irq_flag <= 1'b0;
    wr(8'h00, 32'h07, 2'h0);
    core(1'b1, 12'h100, 12'he00, 1'b0);
    wr(8'h00, 32'h03, 2'h0);
    // First store edge past the four-cycle window is refused.
    repeat (3) @(posedge aclk);
    core(1'b1, 12'h100, 12'he00, 1'b0);
    // Last store edge inside the window is still taken; all-ones data keeps the locks.
    lock_data <= 4'hf;
    wr(8'h00, 32'h09, 2'h0);
    repeat (2) @(posedge aclk);
    core(1'b1, 12'h000, 12'he00, 1'b1);
    wr(8'h00, 32'h03, 2'h0);
    core(1'b1, 12'h100, 12'he00, 1'b1);
    @(negedge aclk);
    chk("halt", 32'h0, {31'h0, cpu_halt});
    @(posedge aclk);
    core(1'b0, 12'h100, 12'he00, 1'b0);
    core(1'b0, 12'hc10, 12'he00, 1'b1);
    rd(8'h00, 32'h40, 32'h40, 2'h0);
    settle();
    wr(8'h00, 32'h01, 2'h0);
    core(1'b1, 12'h104, 12'he00, 1'b1);
    @(negedge aclk);
    chk("busy", 32'h0, {31'h0, concurrent_region_blocked});
    @(posedge aclk);
    // Concurrent page write, then software re-enables the region before reading it.
    wr(8'h00, 32'h05, 2'h0);
    core(1'b1, 12'h108, 12'he00, 1'b1);
    rd(8'h00, 32'h40, 32'h40, 2'h0);
    settle();
    wr(8'h00, 32'h11, 2'h0);
    core(1'b1, 12'h108, 12'he00, 1'b1);
    @(negedge aclk);
    chk("busy", 32'h0, {31'h0, concurrent_region_blocked});
    chk("abort", 32'h1, {31'h0, flash_abort});
    @(posedge aclk);
    core(1'b0, 12'h100, 12'he00, 1'b1);
    wr(8'h00, 32'h05, 2'h0);
    core(1'b1, 12'hd00, 12'he00, 1'b1);
    @(negedge aclk);
    chk("halt", 32'h1, {31'h0, cpu_halt});
    settle();
    chk("halt", 32'h0, {31'h0, cpu_halt});
    wr(8'h00, 32'h09, 2'h0);
    lock_data <= 4'h2;
    core(1'b1, 12'h0, 12'he00, 1'b1);
    rd(8'h04, 32'hf, 32'h2, 2'h0);
    wr(8'h00, 32'h03, 2'h0);
    core(1'b1, 12'h100, 12'he00, 1'b0);
    core(1'b0, 12'he10, 12'h100, 1'b0);
    core(1'b0, 12'h100, 12'he10, 1'b1);
    @(negedge aclk);
    chk("irqdis", 32'h1, {31'h0, irq_disable});
    chk("vector", 32'h0, {20'h0, reset_vector});
    @(posedge aclk);
    chip_erase <= 1'b1;
    boot_reset_select_fuse <= 1'b0;
    repeat (4) @(posedge aclk);
    chip_erase <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(8'h04, 32'hf, 32'hf, 2'h0);
    chk("vector", 32'he00, {20'h0, reset_vector});
    // Programmer port sets boot field 10 and application field 01.
    prog_lock_data <= 4'h9;
    prog_lock_we <= 1'b1;
    @(posedge aclk);
    prog_lock_we <= 1'b0;
    rd(8'h04, 32'hf, 32'h9, 2'h0);
    wr(8'h00, 32'h03, 2'h0);
    core(1'b1, 12'he20, 12'he00, 1'b0);
    core(1'b0, 12'h100, 12'he10, 1'b0);
    vectors_in_boot <= 1'b1;
    core(1'b0, 12'he10, 12'h100, 1'b1);
    @(negedge aclk);
    chk("irqdis", 32'h1, {31'h0, irq_disable});
    @(posedge aclk);
    wr(8'h08, 32'h1, 2'h2);
    rd(8'h08, 32'h1, 32'h0, 2'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
